/* File: logic/iom_output_mux.v */
// Bus slave holding four retained words and driving six outputs from a source
//
// Summary of operation
// - Floating source pin at power-up: outputs follow hardware inputs.
// - Command 00 then four bytes store words 0, 1, 2, 3 in order.
// - Each retained word holds six bits, one per output line.
// - Command F2 connects the outputs to the hardware setting inputs.
// - A source chosen over the bus overrides the source-select pin.
// - Command FF then repeated-start read returns current hardware input levels.
// - Writes to the retained words are accepted while write-protect is low.
// - Retained words survive power-down and reset for later selection.
// - With hardware inputs selected, each output follows its input bit.
// - Without bus selection, the source pin picks stored word or inputs.
// - The address strap is compared with the lowest slave address bit.
module iom_output_mux (
	// Clock and reset
	input  wire       clk,
	input  wire       resetn,
	// Serial bus pins
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_oe,
	// Straps and control pins
	input  wire       low_address_strap,
	input  wire       write_protect,
	input  wire       source_select_hw,
	// Hardware setting inputs and multiplexed outputs
	input  wire [5:0] hw_setting,
	output reg  [5:0] out_value
);

`include "iom_regs.vh"

	localparam ST_IDLE = 3'd0;
	localparam ST_RECV = 3'd1;
	localparam ST_ACK  = 3'd2;
	localparam ST_SEND = 3'd3;
	localparam ST_RACK = 3'd4;

	wire [9:0] pins_sync;
	wire       scl;
	wire       sda;
	wire       strap;
	wire       wp;
	wire       sel_pin;
	wire [5:0] hw_in;

	iom_sync #(
		.WIDTH(10)
	) u_sync (
		.clk      (clk),
		.resetn   (resetn),
		.async_in ({scl_in, sda_in, low_address_strap, write_protect,
			hw_setting}),
		.sync_out (pins_sync)
	);

	assign scl   = pins_sync[9];
	assign sda   = pins_sync[8];
	assign strap = pins_sync[7];
	assign wp    = pins_sync[6];
	assign hw_in = pins_sync[5:0];

	// The select pin only settles once, but it gets its own two-flop synchroniser instance
	iom_sync #(
		.WIDTH(1)
	) u_sel_sync (
		.clk      (clk),
		.resetn   (resetn),
		.async_in (source_select_hw),
		.sync_out (sel_pin)
	);

	reg       scl_prev;
	reg       sda_prev;
	reg [2:0] state;
	reg [3:0] bit_cnt;
	reg [7:0] shreg;
	reg [7:0] tx;
	reg       is_addr;
	reg       is_cmd;
	reg       rd_mode;
	reg       nack;
	reg [2:0] ptr;
	reg       sw_valid;
	reg       sw_hw;
	reg [1:0] sw_word;
	reg [5:0] nv_word [0:3];

	wire scl_rise = scl & ~scl_prev;
	wire scl_fall = ~scl & scl_prev;
	wire start_c  = scl & scl_prev & sda_prev & ~sda;
	wire stop_c   = scl & scl_prev & ~sda_prev & sda;

	// Byte returned on a read for a given pointer
	function [7:0] rd_byte;
		input [2:0] p;
		input [5:0] inputs;
		input [5:0] w0;
		input [5:0] w1;
		input [5:0] w2;
		input [5:0] w3;
		begin
			if (p == `IOM_PTR_INPUTS)
				rd_byte = {2'b00, inputs};
			else if (p == 3'd0)
				rd_byte = {2'b00, w0};
			else if (p == 3'd1)
				rd_byte = {2'b00, w1};
			else if (p == 3'd2)
				rd_byte = {2'b00, w2};
			else if (p == 3'd3)
				rd_byte = {2'b00, w3};
			else
				rd_byte = 8'hFF;
		end
	endfunction

	// Pointer after a word access; stops past the last word
	function [2:0] ptr_step;
		input [2:0] p;
		begin
			if (p[2])
				ptr_step = p;
			else if (p == 3'd3)
				ptr_step = `IOM_PTR_NONE;
			else
				ptr_step = p + 3'd1;
		end
	endfunction

	wire [7:0] cur_rd = rd_byte(ptr, hw_in, nv_word[0], nv_word[1],
		nv_word[2], nv_word[3]);
	wire       addr_hit = (shreg[7:1] == {`IOM_ADDR_HI, strap});
	wire       data_wr  = (state == ST_RECV) && scl_fall && bit_cnt == 4'd8 &&
		!is_addr && !is_cmd && !ptr[2];

	// Retained words carry no reset so their contents outlive any reset
	always @(posedge clk) begin
		if (data_wr && !wp) begin
			nv_word[ptr[1:0]] <= shreg[5:0];
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
			state    <= ST_IDLE;
			bit_cnt  <= 4'h0;
			shreg    <= 8'h00;
			tx       <= 8'hFF;
			is_addr  <= 1'b0;
			is_cmd   <= 1'b0;
			rd_mode  <= 1'b0;
			nack     <= 1'b0;
			ptr      <= `IOM_PTR_NONE;
			sw_valid <= 1'b0;
			sw_hw    <= 1'b0;
			sw_word  <= 2'd0;
			sda_oe   <= 1'b0;
			sda_out  <= 1'b0;
		end else begin
			scl_prev <= scl;
			sda_prev <= sda;
			sda_out  <= 1'b0;
			if (start_c) begin
				// A repeated start keeps the pointer for the following read
				state   <= ST_RECV;
				bit_cnt <= 4'h0;
				is_addr <= 1'b1;
				is_cmd  <= 1'b0;
				sda_oe  <= 1'b0;
			end else if (stop_c) begin
				state  <= ST_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (state)
				ST_RECV: begin
					if (scl_rise && bit_cnt != 4'd8) begin
						shreg   <= {shreg[6:0], sda};
						bit_cnt <= bit_cnt + 4'd1;
					end else if (scl_fall && bit_cnt == 4'd8) begin
						state <= ST_ACK;
						if (is_addr) begin
							if (addr_hit) begin
								sda_oe  <= 1'b1;
								rd_mode <= shreg[0];
								is_addr <= 1'b0;
								is_cmd  <= ~shreg[0];
								tx      <= cur_rd;
							end else begin
								state <= ST_IDLE;
							end
						end else if (is_cmd) begin
							sda_oe <= 1'b1;
							is_cmd <= 1'b0;
							if (shreg == `IOM_CMD_SEL_HW) begin
								sw_valid <= 1'b1;
								sw_hw    <= 1'b1;
							end else if (shreg == `IOM_CMD_RD_INPUTS) begin
								ptr <= `IOM_PTR_INPUTS;
							end else if (shreg[7:2] == `IOM_CMD_SEL_WORD_HI) begin
								sw_valid <= 1'b1;
								sw_hw    <= 1'b0;
								sw_word  <= shreg[1:0];
							end else if ((shreg & 8'hFC) == `IOM_CMD_WRITE_WORDS) begin
								ptr <= {1'b0, shreg[1:0]};
							end else begin
								ptr <= `IOM_PTR_NONE;
							end
						end else begin
							// Protected writes are still acknowledged
							sda_oe <= 1'b1;
							ptr    <= ptr_step(ptr);
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (rd_mode) begin
							state   <= ST_SEND;
							sda_oe  <= ~tx[7];
							tx      <= {tx[6:0], 1'b1};
							bit_cnt <= 4'd1;
							ptr     <= ptr_step(ptr);
						end else begin
							state  <= ST_RECV;
							sda_oe <= 1'b0;
						end
					end
				end
				ST_SEND: begin
					if (scl_fall) begin
						if (bit_cnt == 4'd8) begin
							state  <= ST_RACK;
							sda_oe <= 1'b0;
						end else begin
							sda_oe  <= ~tx[7];
							tx      <= {tx[6:0], 1'b1};
							bit_cnt <= bit_cnt + 4'd1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						nack <= sda;
					end else if (scl_fall) begin
						if (nack) begin
							state <= ST_IDLE;
						end else begin
							state   <= ST_SEND;
							sda_oe  <= ~cur_rd[7];
							tx      <= {cur_rd[6:0], 1'b1};
							bit_cnt <= 4'd1;
							ptr     <= ptr_step(ptr);
						end
					end
				end
				default: begin
					sda_oe <= 1'b0;
				end
				endcase
			end
		end
	end

	// Output source: bus choice first, then the select pin
	reg [5:0] next_out;
	always @* begin
		if (sw_valid && sw_hw)
			next_out = hw_in;
		else if (sw_valid)
			next_out = nv_word[sw_word];
		else if (sel_pin)
			next_out = hw_in;
		else
			next_out = nv_word[0];
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			out_value <= `IOM_OUT_RESET;
		else
			out_value <= next_out;
	end

endmodule

/* File: logic/iom_regs.vh */
// Constants for the bus-driven six-bit output multiplexer
`ifndef IOM_REGS_VH
`define IOM_REGS_VH

// Upper six bits of the slave address; the strap supplies the lowest bit
`define IOM_ADDR_HI         6'h26
// Command bytes
`define IOM_CMD_WRITE_WORDS 8'h00
`define IOM_CMD_SEL_HW      8'hF2
`define IOM_CMD_RD_INPUTS   8'hFF
// Commands F4..F7 select stored word 0..3 as output source
`define IOM_CMD_SEL_WORD_HI 6'h3D
// Read pointer codes: 0..3 stored words, 4 hardware inputs, 7 nothing
`define IOM_PTR_INPUTS      3'h4
`define IOM_PTR_NONE        3'h7
// Reset values
`define IOM_OUT_RESET       6'h00

`endif

/* File: logic/iom_sync.v */
// Two-flop synchroniser for a group of asynchronous inputs
module iom_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input  wire             clk,
	input  wire             resetn,
	// Asynchronous inputs and their synchronised copies
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] stage1;

	// First stage feeds only the second stage
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stage1   <= {WIDTH{1'b1}};
			sync_out <= {WIDTH{1'b1}};
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

/* File: verification/iom_checker.sv */
// Assertion checker for the six-bit output multiplexer
module iom_checker (
	// Ports
	input wire       clk,
	input wire       resetn,
	input wire       scl_in,
	input wire       sda_out,
	input wire       sda_oe,
	input wire       write_protect,
	input wire       source_select_hw,
	input wire [5:0] hw_setting,
	input wire [5:0] out_value
);
	timeunit 1ns;
	timeprecision 1ns;
	reg used;
	// Once the device has answered, the bus may own the source choice
	always @(posedge clk or negedge resetn)
		if (!resetn)
			used <= 1'b0;
		else if (sda_oe)
			used <= 1'b1;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_pin_default: assert property ((!used && source_select_hw
		&& $stable({source_select_hw, hw_setting}))[*5]
		|-> out_value == hw_setting) else $error("pin source");
	a_reset_quiet: assert property (disable iff (1'b0)
		!resetn |-> out_value == 6'h00 && !sda_oe) else $error("reset");
	a_out_settled: assert property ((scl_in
		&& $stable({source_select_hw, hw_setting}))[*8]
		|-> $stable(out_value)) else $error("out moved");
	a_drive_low: assert property (sda_oe |-> !sda_out)
		else $error("drive high");
	a_edge_scl_low: assert property ($changed(sda_oe)
		|-> $past(!scl_in, 2)) else $error("edge");
	a_ack_width: assert property ($rose(sda_oe) |-> sda_oe[*6])
		else $error("short drive");
	a_drive_bounded: assert property ($rose(sda_oe)
		|-> ##[1:90] !sda_oe) else $error("long drive");
	a_idle_release: assert property (scl_in[*8] |-> !sda_oe)
		else $error("idle drive");
	cover property ($rose(sda_oe) && write_protect);
	cover property ($fell(source_select_hw));
	cover property (used && out_value == 6'h0D);
endmodule
bind iom_output_mux iom_checker u_chk (.clk, .resetn, .scl_in, .sda_out,
	.sda_oe, .write_protect, .source_select_hw, .hw_setting, .out_value);

/* File: verification/iom_master.sv */
// Bus master model driving the serial clock and data lines
module iom_master (
	// Pacing clock, resolved data wire, driven lines
	input  wire clk,
	input  wire sda,
	output reg  scl = 1'b1,
	output reg  sda_m = 1'b1
);
	timeunit 1ns;
	timeprecision 1ns;
	// Half of the 400 ns link period; clock stands high between frames
	task hc;
		repeat (4) @(posedge clk);
		#2;
	endtask
	task sbit(input b, output r);
		sda_m = b;
		hc;
		scl = 1'b1;
		hc;
		r = sda;
		scl = 1'b0;
	endtask
	// s=1 gives a start or repeated start, s=0 a stop
	task cond(input s);
		sda_m = s;
		hc;
		scl = 1'b1;
		hc;
		sda_m = !s;
		hc;
		scl = !s;
	endtask
	// Most significant bit first; ninth bit drives m and samples the acknowledge
	task xfer(input [7:0] d, input m, output [7:0] q, output ack);
		reg a;
		for (int i = 7; i >= 0; i--)
			sbit(d[i], q[i]);
		sbit(m, a);
		ack = !a;
	endtask
endmodule

/* File: verification/iom_output_mux_tb_top.sv */
// Self-checking bench for the six-bit output multiplexer
module iom_output_mux_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	reg         clk = 0, resetn = 1, strap = 0, wp = 0, pin = 1;
	reg  [5:0]  hw;
	reg  [7:0]  q;
	reg  [7:0]  d;
	reg         ack;
	reg  [31:0] rnd = 32'hE287582E;
	wire        scl, sda_m, sda_out, sda_oe;
	wire [5:0]  outv;
	// Open-drain wire: low while either side pulls it
	wire        sda = sda_m & (sda_oe ? sda_out : 1'b1);
	int         n_errors = 0, compares = 0, cyc = 0, sel = -1;
	int         w[4];
	iom_master u_m (.clk, .sda, .scl, .sda_m);
	iom_output_mux DUT (.clk, .resetn, .scl_in(scl), .sda_in(sda),
		.sda_out, .sda_oe, .low_address_strap(strap), .write_protect(wp),
		.source_select_hw(pin), .hw_setting(hw), .out_value(outv));
	always #25 clk = ~clk;
	always @(posedge clk)
		if (++cyc > 6000) begin
			n_errors++;
			wrap_up;
		end
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [7:0] adr(input r);
		adr = {6'h26, strap, r};
	endfunction
	function [5:0] expv;
		expv = sel == 4 || sel < 0 && pin ? hw : w[sel < 0 ? 0 : sel];
	endfunction
	task chk(input [7:0] got, input [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t %h %h", $time, got, exp);
		end
	endtask
	task send(input [7:0] d, input a);
		u_m.xfer(d, 1'b1, q, ack);
		chk(ack, a);
	endtask
	// Write a command, then read n bytes after a repeated start
	task rd(input [7:0] c, input int n, input [31:0] e);
		u_m.cond(1);
		send(adr(1'b0), 1);
		send(c, 1);
		u_m.cond(1);
		send(adr(1'b1), 1);
		for (int i = 0; i < n; i++) begin
			u_m.xfer(8'hFF, i == n - 1, q, ack);
			chk(q, e[31 - 8 * i -: 8]);
		end
		u_m.cond(0);
	endtask
	task settle;
		u_m.hc;
		u_m.hc;
	endtask
	task wrap_up;
		if (n_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#2 resetn = 0;
		rnd = lfsr(rnd);
		hw = rnd[5:0];
		strap = rnd[8];
		repeat (5) @(posedge clk);
		#2 resetn = 1;
		settle;
		chk(outv, expv());
		u_m.cond(1);
		send({6'h26, ~strap, 1'b0}, 0);
		u_m.cond(0);
		strap = ~strap;
		u_m.cond(1);
		send(adr(1'b0), 1);
		send(8'h00, 1);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			w[i] = rnd[5:0];
			send(rnd[7:0], 1);
		end
		u_m.cond(0);
		rd(8'h01, 4, {2'b00, w[1][5:0], 2'b00, w[2][5:0],
			2'b00, w[3][5:0], 8'hFF});
		rd(8'h80, 1, {8'hFF, 24'h0});
		for (int i = 0; i < 5; i++) begin
			u_m.cond(1);
			send(adr(1'b0), 1);
			send(i < 4 ? 8'hF4 + i : 8'hF2, 1);
			u_m.cond(0);
			sel = i;
			chk(outv, expv());
		end
		hw = 6'h0D;
		settle;
		chk(outv, 8'h0D);
		rd(8'hFF, 1, {2'b00, hw, 24'h0});
		rnd = lfsr(rnd);
		hw = rnd[5:0];
		settle;
		chk(outv, expv());
		// Two writes to word 0 with opposite protect levels
		rnd = lfsr(rnd);
		for (int k = 0; k < 2; k++) begin
			wp = k ? ~wp : rnd[9];
			d = k ? ~rnd[7:0] : rnd[7:0];
			u_m.cond(1);
			send(adr(1'b0), 1);
			send(8'h00, 1);
			send(d, 1);
			u_m.cond(0);
			if (!wp)
				w[0] = d[5:0];
		end
		resetn = 0;
		pin = rnd[10];
		sel = -1;
		settle;
		resetn = 1;
		settle;
		chk(outv, expv());
		pin = ~pin;
		settle;
		chk(outv, expv());
		wrap_up;
	end
endmodule
